// ==== src/dio_format_consts.vh ====
// Constants for the digital audio I/O format logic
`ifndef DIO_FORMAT_CONSTS_VH
`define DIO_FORMAT_CONSTS_VH
`define ADR_CTRL        4'h0
`define ADR_STATUS      4'h1
`define ADR_SLOT        4'h2
`define ADR_CS_COAX     4'h3
`define ADR_CS_OPT      4'h4
`define ADR_ID          4'h5
`define CTRL_RST        32'h0000_0000
`define CTRL_PRO        0
`define CTRL_OPT_STEREO 1
`define CTRL_SRC_LO     2
`define CTRL_SRC_HI     3
`define CTRL_SRC_EN     4
`define CTRL_QUAD       5
`define SRC_COAX        2'h0
`define SRC_PRO         2'h1
`define SRC_OPT         2'h2
`define SPEED_SINGLE    2'h0
`define SPEED_DOUBLE    2'h1
`define SPEED_QUAD      2'h2
`define CH_OPT_L        5'h06
`define CH_OPT_R        5'h07
`define CS_PRO_BIT      0
`define CS_EMPH_BITS    3'h0
`define SLOT_USER_MAX   4'h5
`define SLOT_FACTORY    4'h6
`define SLOT_CONVERTER  4'h7
`define SLOT_CLEAR      4'h8
`define OP_LOAD         1'b0
`define OP_STORE        1'b1
`define CLK_HZ          40000000
`define HOLD_MS         1000
`define SRC_LAT_US      2500
`define MIDI_LED_MS     50
`define RATIO_MAX       3'h7
`define UI_METER        3'b001
`define UI_CHANNEL      3'b010
`define UI_MIX          3'b100
`define UI_GAIN         3'b010
`endif

// ==== src/dio_format_logic.v ====
// Digital audio I/O format, channel mapping, rate converter control and front panel logic
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dio_format_consts.vh"
module dio_format_logic #(
   parameter        SW         = 24,
   parameter [31:0] HOLD_CYC   = (`CLK_HZ / 1000) * `HOLD_MS,
   parameter [31:0] LAT_CYC    = (`CLK_HZ / 1000) * `SRC_LAT_US / 1000,
   parameter [31:0] LED_CYC    = (`CLK_HZ / 1000) * `MIDI_LED_MS,
   parameter [31:0] DEVICE_ID  = 32'h0000_a5a5   // Arbitrary value
) (
   // Clock and reset
   input  wire          clk_i,
   input  wire          rst_n_i,
   // Avalon-MM slave
   input  wire [3:0]    avs_address_i,
   input  wire          avs_read_i,
   input  wire          avs_write_i,
   input  wire [31:0]   avs_writedata_i,
   output reg  [31:0]   avs_readdata_o,
   output wire          avs_waitrequest_o,
   // Receivers: frame strobe, lock, samples
   input  wire          coax_frame_i,
   input  wire          coax_lock_i,
   input  wire [SW-1:0] coax_l_i,
   input  wire [SW-1:0] coax_r_i,
   input  wire          pro_frame_i,
   input  wire          pro_lock_i,
   input  wire [SW-1:0] pro_l_i,
   input  wire [SW-1:0] pro_r_i,
   input  wire          opt_frame_i,
   input  wire          opt_lock_i,
   input  wire          opt_stereo_det_i,
   input  wire          opt_double_id_i,
   input  wire [8*SW-1:0] opt_ch_i,
   // Reference frame strobe and converter input and output rate ratio estimates
   input  wire          ref_frame_i,
   input  wire [2:0]    src_in_ratio_i,
   input  wire [2:0]    src_out_ratio_i,
   // Channels routed to the outputs
   input  wire [8*SW-1:0] opt_out_ch_i,
   // Received MIDI byte strobe
   input  wire          midi_byte_i,
   // Front panel
   input  wire          key_gain_i,
   input  wire          channel_mixer_key_i,
   input  wire          enc_push_i,
   // Input channel block (channels 1..8 = optical)
   output reg  [8*SW-1:0] in_ch_o,
   output reg  [1:0]    in_speed_o,
   output reg           opt_in_stereo_o,
   // Outputs: fresh status bytes and optical lane data
   output reg  [7:0]    coax_cs0_o,
   output reg  [7:0]    pro_cs0_o,
   output reg  [7:0]    opt_cs0_o,
   output reg  [8*SW-1:0] opt_out_o,
   output reg           opt_out_stereo_o,
   // Rate converter output
   output reg           src_frame_o,
   output reg  [SW-1:0] src_l_o,
   output reg  [SW-1:0] src_r_o,
   // Indicators and panel state
   output reg           midi_led_o,
   output reg  [2:0]    ui_chmix_o,
   output reg  [2:0]    ui_gain_o,
   output reg           slot_go_o,
   output reg           slot_op_o,
   output reg  [3:0]    slot_sel_o
);

   // 128 samples cover the path delay only up to 48 kHz frames; faster rates wrap
   localparam DEPTH = 128;
   localparam AW    = 7;

   reg  [31:0]   ctrl;
   reg  [3:0]    slot_reg;
   reg           slot_op_reg;
   reg  [31:0]   hold_cnt;
   reg           hold_done;
   reg  [31:0]   led_cnt;
   reg           key_gain_q;
   reg           key_cm_q;
   reg           double_seen;
   reg  [2*SW-1:0] dly [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr;
   reg  [AW-1:0] rd_ptr;
   reg  [31:0]   fill;
   reg           src_lock_q;
   reg           src_in_frame;
   reg           src_in_lock;
   reg  [SW-1:0] src_in_l;
   reg  [SW-1:0] src_in_r;
   wire          ratio_ok;
   wire          src_ok;
   wire [1:0]    src_sel;
   reg           rd_wait;
   reg  [31:0]   rd_mux;
   integer       i;
   integer       j;

   // Writes finish at once; a read waits one cycle so its data leaves a flip-flop
   assign avs_waitrequest_o = avs_read_i && !rd_wait;
   assign src_sel = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];
   // Converter refused on optical while it carries eight channels
   assign src_ok  = ctrl[`CTRL_SRC_EN] &&
                    !(src_sel == `SRC_OPT && !opt_in_stereo_o);
   // A zero term means no rate estimate yet
   assign ratio_ok = (src_in_ratio_i <= `RATIO_MAX) && (src_out_ratio_i <= `RATIO_MAX) &&
                     (src_in_ratio_i != 3'h0) && (src_out_ratio_i != 3'h0);

   // Register writes
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl        <= `CTRL_RST;
         slot_reg    <= 4'h0;
         slot_op_reg <= `OP_LOAD;
      end else if (avs_write_i) begin
         case (avs_address_i)
            `ADR_CTRL: ctrl <= avs_writedata_i;
            // Slot numbers past the clear slot are ignored; the op bit still updates
            `ADR_SLOT: begin
               if (avs_writedata_i[3:0] <= `SLOT_CLEAR)
                  slot_reg <= avs_writedata_i[3:0];
               slot_op_reg <= avs_writedata_i[4];
            end
            default: ;
         endcase
      end
   end

   // Register reads, zero on unmapped words
   // Status: 9 locked, 8 ratio ok, 7 allowed, 6 lamp, 5 double, 4 stereo, 3:2 speed
   always @* begin
      case (avs_address_i)
         `ADR_CTRL:    rd_mux = ctrl;
         `ADR_STATUS:  rd_mux = {22'h0, src_lock_q, ratio_ok, src_ok, midi_led_o,
                                 double_seen, opt_in_stereo_o, in_speed_o, 2'h0};
         `ADR_SLOT:    rd_mux = {27'h0, slot_op_reg, slot_reg};
         `ADR_CS_COAX: rd_mux = {24'h0, coax_cs0_o};
         `ADR_CS_OPT:  rd_mux = {24'h0, opt_cs0_o};
         `ADR_ID:      rd_mux = DEVICE_ID;
         default:      rd_mux = 32'h0;
      endcase
   end

   // Read data registered during the wait cycle
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_wait        <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else begin
         rd_wait        <= avs_read_i && !rd_wait;
         avs_readdata_o <= rd_mux;
      end
   end

   // Input format detection and channel mapping
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         opt_in_stereo_o <= 1'b0;
         double_seen     <= 1'b0;
         in_speed_o      <= `SPEED_SINGLE;
         in_ch_o         <= {8*SW{1'b0}};
      end else begin
         opt_in_stereo_o <= opt_lock_i & opt_stereo_det_i;
         // Lock loss forgets the double-rate identifier at once
         if (!opt_lock_i)
            double_seen <= 1'b0;
         else if (opt_frame_i)
            double_seen <= opt_double_id_i;
         // Quad has no identifier, so only the control bit selects it
         if (ctrl[`CTRL_QUAD])
            in_speed_o <= `SPEED_QUAD;
         else if (double_seen)
            in_speed_o <= `SPEED_DOUBLE;
         else
            in_speed_o <= `SPEED_SINGLE;
         if (opt_frame_i) begin
            for (i = 0; i < 8; i = i + 1) begin
               // A stereo stream fills only the first pair; the rest goes silent
               if (opt_stereo_det_i && i > 1)
                  in_ch_o[i*SW +: SW] <= {SW{1'b0}};
               else if ((in_speed_o == `SPEED_DOUBLE && i > 3) ||
                        (in_speed_o == `SPEED_QUAD && i > 1))
                  in_ch_o[i*SW +: SW] <= {SW{1'b0}};
               else
                  in_ch_o[i*SW +: SW] <= opt_ch_i[i*SW +: SW];
            end
         end
      end
   end

   // Fresh channel status; received status and emphasis never pass through
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         coax_cs0_o <= 8'h00;
         pro_cs0_o  <= 8'h01;
         opt_cs0_o  <= 8'h00;
      end else begin
         // Emphasis stays clear: nothing downstream could undo it
         coax_cs0_o <= {4'h0, `CS_EMPH_BITS, ctrl[`CTRL_PRO]};
         pro_cs0_o  <= {4'h0, `CS_EMPH_BITS, 1'b1};
         opt_cs0_o  <= {4'h0, `CS_EMPH_BITS, 1'b0};
      end
   end

   // Optical output lanes
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         opt_out_o        <= {8*SW{1'b0}};
         opt_out_stereo_o <= 1'b0;
      end else begin
         opt_out_stereo_o <= ctrl[`CTRL_OPT_STEREO];
         // Stereo mode wins over the speed rule: only lanes 1/2 carry audio
         for (j = 0; j < 8; j = j + 1) begin
            if (ctrl[`CTRL_OPT_STEREO] && j > 1)
               opt_out_o[j*SW +: SW] <= {SW{1'b0}};
            else if ((in_speed_o == `SPEED_DOUBLE && j > 3) ||
                     (in_speed_o == `SPEED_QUAD && j > 1))
               opt_out_o[j*SW +: SW] <= {SW{1'b0}};
            else
               opt_out_o[j*SW +: SW] <= opt_out_ch_i[j*SW +: SW];
         end
      end
   end

   // Converter input select
   always @* begin
      case (src_sel)
         `SRC_PRO: begin
            src_in_frame = pro_frame_i;
            src_in_lock  = pro_lock_i;
            src_in_l     = pro_l_i;
            src_in_r     = pro_r_i;
         end
         `SRC_OPT: begin
            src_in_frame = opt_frame_i;
            src_in_lock  = opt_lock_i;
            src_in_l     = opt_ch_i[SW-1:0];
            src_in_r     = opt_ch_i[2*SW-1:SW];
         end
         default: begin
            src_in_frame = coax_frame_i;
            src_in_lock  = coax_lock_i;
            src_in_l     = coax_l_i;
            src_in_r     = coax_r_i;
         end
      endcase
   end

   // Converter: sample buffer emulating path delay, read on reference frames.
   // Arithmetic interpolation is outside this block; it only paces and gates data.
   // Filled on the selected input's own frames, emptied on the reference frames
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr      <= {AW{1'b0}};
         rd_ptr      <= {AW{1'b0}};
         fill        <= 32'h0;
         src_lock_q  <= 1'b0;
         src_frame_o <= 1'b0;
         src_l_o     <= {SW{1'b0}};
         src_r_o     <= {SW{1'b0}};
      end else begin
         src_lock_q  <= src_ok & src_in_lock & ratio_ok;
         src_frame_o <= ref_frame_i;
         if (src_ok && src_in_frame) begin
            dly[wr_ptr] <= {src_in_r, src_in_l};
            wr_ptr      <= wr_ptr + 1'b1;
         end
         if (!src_lock_q)
            fill <= 32'h0;
         else if (fill < LAT_CYC)
            fill <= fill + 32'h1;
         if (ref_frame_i) begin
            if (src_lock_q && fill >= LAT_CYC && rd_ptr != wr_ptr) begin
               {src_r_o, src_l_o} <= dly[rd_ptr];
               rd_ptr <= rd_ptr + 1'b1;
            end else begin
               src_l_o <= {SW{1'b0}};
               src_r_o <= {SW{1'b0}};
               if (!src_lock_q)
                  rd_ptr <= wr_ptr;
            end
         end
      end
   end

   // MIDI activity: any byte retriggers the indicator
   // A steady stream of bytes keeps the lamp lit without flicker
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         led_cnt    <= 32'h0;
         midi_led_o <= 1'b0;
      end else if (midi_byte_i) begin
         led_cnt    <= LED_CYC;
         midi_led_o <= 1'b1;
      end else if (led_cnt != 32'h0) begin
         led_cnt    <= led_cnt - 32'h1;
         midi_led_o <= (led_cnt != 32'h1);
      end
   end

   // Front panel keys and long push
   // Edge detectors reset low, so a key held through reset steps its menu once just after reset
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         key_gain_q <= 1'b0;
         key_cm_q   <= 1'b0;
         ui_chmix_o <= `UI_METER;
         ui_gain_o  <= `UI_METER;
         hold_cnt   <= 32'h0;
         hold_done  <= 1'b0;
         slot_go_o  <= 1'b0;
         slot_op_o  <= `OP_LOAD;
         slot_sel_o <= 4'h0;
      end else begin
         key_gain_q <= key_gain_i;
         key_cm_q   <= channel_mixer_key_i;
         slot_go_o  <= 1'b0;
         if (channel_mixer_key_i && !key_cm_q) begin
            case (ui_chmix_o)
               `UI_METER:   ui_chmix_o <= `UI_CHANNEL;
               `UI_CHANNEL: ui_chmix_o <= `UI_MIX;
               default:     ui_chmix_o <= `UI_METER;
            endcase
         end
         if (key_gain_i && !key_gain_q) begin
            case (ui_gain_o)
               `UI_METER: ui_gain_o <= `UI_GAIN;
               default:   ui_gain_o <= `UI_METER;
            endcase
         end
         // A long push fires once; releasing the encoder re-arms it
         if (!enc_push_i) begin
            hold_cnt  <= 32'h0;
            hold_done <= 1'b0;
         end else if (!hold_done) begin
            if (hold_cnt >= HOLD_CYC) begin
               hold_done  <= 1'b1;
               slot_go_o  <= 1'b1;
               slot_op_o  <= slot_op_reg;
               slot_sel_o <= slot_reg;
            end else begin
               hold_cnt <= hold_cnt + 32'h1;
            end
         end
      end
   end

endmodule // dio_format_logic

// ==== bench/dio_format_assertions.sv ====
// Port-level assertions for the digital audio format logic
`timescale 1ns/1ps
module dio_format_checker #(
   parameter [31:0] HOLD_CYC = 10
) (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   // Causes
   input wire logic       ref_frame_i,
   input wire logic       midi_byte_i,
   input wire logic       key_gain_i,
   input wire logic       channel_mixer_key_i,
   input wire logic       enc_push_i,
   // Effects
   input wire logic [1:0] in_speed_o,
   input wire logic [7:0] coax_cs0_o,
   input wire logic [7:0] pro_cs0_o,
   input wire logic [7:0] opt_cs0_o,
   input wire logic       opt_out_stereo_o,
   input wire logic       src_frame_o,
   input wire logic       midi_led_o,
   input wire logic [2:0] ui_chmix_o,
   input wire logic [2:0] ui_gain_o,
   input wire logic       slot_go_o
);
   logic [31:0] held;
   logic [2:0]  last_chmix;
   logic [2:0]  last_gain;
   // Push length counted here so the hold check can name an exact figure
   always @(posedge clk_i) begin
      held       <= (rst_n_i && enc_push_i) ? held + 32'h1 : 32'h0;
      last_chmix <= ui_chmix_o;
      last_gain  <= ui_gain_o;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence chmix_press;
      $rose(channel_mixer_key_i);
   endsequence
   sequence gain_press;
      $rose(key_gain_i);
   endsequence
   emph_clear_a: assert property ((coax_cs0_o[3:1] | pro_cs0_o[3:1] | opt_cs0_o[3:1]) == 3'h0)
      else $error("emphasis bits set");
   opt_consumer_a: assert property (opt_out_stereo_o |-> !opt_cs0_o[0])
      else $error("optical stereo not consumer");
   src_frame_a: assert property (ref_frame_i |=> src_frame_o)
      else $error("converter frame missing");
   midi_lamp_a: assert property (midi_byte_i |=> midi_led_o)
      else $error("midi lamp not lit");
   slot_hold_a: assert property (slot_go_o |-> held > HOLD_CYC)
      else $error("slot command on short push");
   slot_once_a: assert property (slot_go_o |=> !slot_go_o)
      else $error("slot command repeated");
   chmix_step_a: assert property (chmix_press |=> ui_chmix_o == {last_chmix[1:0], last_chmix[2]})
      else $error("channel menu step wrong");
   gain_step_a: assert property (gain_press |=> ui_gain_o == ((last_gain == 3'b001) ? 3'b010 : 3'b001))
      else $error("gain page toggle wrong");
   speed_legal_a: assert property (in_speed_o != 2'h3)
      else $error("illegal speed code");
endmodule // dio_format_checker

// ==== bench/audio_partner.sv ====
// Behavioural far-side audio source: frame strobe, lock level and sample lanes
`timescale 1ns/1ps
module audio_partner #(
   parameter SW  = 24,
   parameter CH  = 2,
   parameter PER = 16
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Bench control
   input  wire logic        lock_en_i,
   // Stream towards the receiver
   output logic             frame_o,
   output logic             lock_o,
   output logic [CH*SW-1:0] ch_o
);
   logic [7:0]    cnt;
   logic [SW-1:0] smp;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_o <= 1'b0;
         lock_o  <= 1'b0;
         ch_o    <= '0;
         cnt     <= 8'h00;
         smp     <= SW'(1);
      end else begin
         frame_o <= 1'b0;
         lock_o  <= lock_en_i;
         cnt     <= (cnt == 8'(PER - 1)) ? 8'h00 : cnt + 8'h01;
         if (!lock_en_i) begin
            ch_o <= ~ch_o; // Idle lanes toggle so stale data never looks valid
         end else if (cnt == 8'h00) begin
            frame_o <= 1'b1; // One fixed rate for every source
            smp     <= smp + SW'(1);
            for (int i = 0; i < CH; i++) ch_o[i*SW +: SW] <= smp + SW'(i * 4096);
         end
      end
   end
endmodule // audio_partner

// ==== bench/testbench.sv ====
// Self-checking bench for the digital audio format logic
`timescale 1ns/1ps
`include "dio_format_consts.vh"
module testbench;
   localparam SW = 24;
   localparam HOLD = 10;
   localparam LED = 5;
   logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, coax_en, pro_en, opt_en;
   logic coax_frame_i, coax_lock_i, pro_frame_i, pro_lock_i, opt_frame_i, opt_lock_i;
   logic opt_stereo_det_i, opt_double_id_i, ref_frame_i, midi_byte_i, slot_go_o, slot_op_o;
   logic key_gain_i, channel_mixer_key_i, enc_push_i, opt_in_stereo_o;
   logic opt_out_stereo_o, src_frame_o, midi_led_o;
   logic [3:0]      avs_address_i, slot_sel_o;
   logic [31:0]     avs_writedata_i, avs_readdata_o, cyc, d;
   logic [SW-1:0]   coax_l_i, coax_r_i, pro_l_i, pro_r_i, src_l_o, src_r_o;
   logic [8*SW-1:0] opt_ch_i, opt_out_ch_i, in_ch_o, opt_out_o, cap;
   logic [2:0]      src_in_ratio_i, src_out_ratio_i, ui_chmix_o, ui_gain_o;
   logic [1:0]      in_speed_o;
   logic [7:0]      coax_cs0_o, pro_cs0_o, opt_cs0_o;
   logic [6:0]      rt [3] = '{7'h73, 7'h1f, 7'h02};
   logic [2:0]      menu [5] = '{`UI_CHANNEL, `UI_MIX, `UI_METER, `UI_GAIN, `UI_METER};
   int              fails, checks, gos;
   dio_format_logic #(.SW(SW), .HOLD_CYC(HOLD), .LAT_CYC(8), .LED_CYC(LED)) uut (.*);
   audio_partner #(.SW(SW), .CH(2)) coax (.clk_i(clk_i), .rst_n_i(rst_n_i), .lock_en_i(coax_en),
      .frame_o(coax_frame_i), .lock_o(coax_lock_i), .ch_o({coax_r_i, coax_l_i}));
   audio_partner #(.SW(SW), .CH(2)) pro (.clk_i(clk_i), .rst_n_i(rst_n_i), .lock_en_i(pro_en),
      .frame_o(pro_frame_i), .lock_o(pro_lock_i), .ch_o({pro_r_i, pro_l_i}));
   audio_partner #(.SW(SW), .CH(8)) opt (.clk_i(clk_i), .rst_n_i(rst_n_i), .lock_en_i(opt_en),
      .frame_o(opt_frame_i), .lock_o(opt_lock_i), .ch_o(opt_ch_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 32'h1;
      ref_frame_i <= (cyc[3:0] == 4'h0);
      if (slot_go_o === 1'b1) gos <= gos + 1;
   end
   task wcyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task chk(input logic [8*SW-1:0] got, input logic [8*SW-1:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task bus(input logic [3:0] a, input logic [31:0] v, input logic w);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= v;
      {avs_write_i, avs_read_i} <= {w, !w};
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      d = avs_readdata_o;
      {avs_write_i, avs_read_i} <= 2'b00;
   endtask
   task push(input int n);
      @(posedge clk_i);
      enc_push_i <= 1'b1;
      wcyc(n);
      enc_push_i <= 1'b0;
      wcyc(3);
   endtask
   task t_status;
      chk({pro_cs0_o, ui_chmix_o, ui_gain_o}, {8'h01, 6'o11}, "reset outputs");
      bus(`ADR_CTRL, 32'h1, 1'b1);
      wcyc(40);
      chk(coax_cs0_o[0], 1'b1, "coax pro");
      chk(opt_out_o, opt_out_ch_i, "eight lanes out");
      bus(`ADR_CTRL, 32'h3, 1'b1);
      wcyc(40);
      chk({opt_out_stereo_o, opt_cs0_o[0]}, 2'b10, "optical consumer");
      chk(opt_out_o[2*SW-1:0], opt_out_ch_i[2*SW-1:0], "optical pair");
      chk(opt_out_o[8*SW-1:2*SW], 0, "optical upper lanes quiet");
      bus(`ADR_CTRL, 32'h0, 1'b0);
      chk(d, 32'h3, "control readback");
      bus(4'hf, 32'h0, 1'b0);
      chk(d, 32'h0, "unmapped read");
   endtask
   task t_src;
      bus(`ADR_CTRL, 32'h10, 1'b1);
      wcyc(40);
      chk(src_l_o, 0, "silent unlocked");
      coax_en <= 1'b1;
      wcyc(4);
      chk(src_r_o, 0, "inside latency");
      wcyc(60);
      bus(`ADR_STATUS, 32'h0, 1'b0);
      chk(d[9:7], 3'b111, "converter state");
      chk(src_l_o != 0, 1'b1, "audio passes");
      for (int i = 0; i < 3; i++) begin
         {src_in_ratio_i, src_out_ratio_i} <= rt[i][6:1];
         wcyc(2);
         bus(`ADR_STATUS, 32'h0, 1'b0);
         chk(d[8], rt[i][0], "ratio range");
      end
      {src_in_ratio_i, src_out_ratio_i} <= 6'o11;
      bus(`ADR_CTRL, 32'h18, 1'b1);
      bus(`ADR_STATUS, 32'h0, 1'b0);
      chk(d[7], 1'b0, "refused on multichannel");
   endtask
   task t_optin;
      opt_en <= 1'b1;
      wcyc(40);
      do @(posedge clk_i); while (opt_frame_i !== 1'b1);
      cap = opt_ch_i;
      wcyc(4);
      chk(in_ch_o, cap, "eight lanes in");
      chk(in_speed_o, `SPEED_SINGLE, "single speed");
      opt_double_id_i <= 1'b1;
      wcyc(40);
      chk(in_speed_o, `SPEED_DOUBLE, "double id");
      chk(in_ch_o[8*SW-1:4*SW], 0, "double lanes in");
      chk(opt_out_o[8*SW-1:4*SW], 0, "double lanes out");
      bus(`ADR_CTRL, 32'h38, 1'b1);
      wcyc(4);
      chk(in_speed_o, `SPEED_QUAD, "quad by control");
      chk(opt_out_o[8*SW-1:2*SW], 0, "quad lanes out");
      opt_stereo_det_i <= 1'b1;
      wcyc(40);
      bus(`ADR_STATUS, 32'h0, 1'b0);
      chk({opt_in_stereo_o, d[4], d[7]}, 3'b111, "optical stereo");
      do @(posedge clk_i); while (opt_frame_i !== 1'b1);
      cap = opt_ch_i;
      wcyc(2);
      chk(in_ch_o, {{6*SW{1'b0}}, cap[2*SW-1:0]}, "stereo pair");
   endtask
   task t_panel;
      int n;
      @(posedge clk_i);
      midi_byte_i <= 1'b1;
      @(posedge clk_i);
      midi_byte_i <= 1'b0;
      @(posedge clk_i);
      chk(midi_led_o, 1'b1, "lamp on");
      wcyc(LED + 3);
      chk(midi_led_o, 1'b0, "lamp off");
      for (int i = 0; i < 5; i++) begin
         {key_gain_i, channel_mixer_key_i} <= (i < 3) ? 2'b01 : 2'b10;
         wcyc(3);
         {key_gain_i, channel_mixer_key_i} <= 2'b00;
         wcyc(3);
         chk((i < 3) ? ui_chmix_o : ui_gain_o, menu[i], "menu step");
      end
      n = gos;
      push(HOLD);
      chk(gos, n, "short push");
      for (int s = 0; s < 10; s++) begin
         bus(`ADR_SLOT, {27'h0, s[0], s[3:0]}, 1'b1);
         push(HOLD + 3);
         chk({slot_sel_o, slot_op_o}, {(s > 8) ? 4'h8 : s[3:0], s[0]}, "slot");
         chk(gos, n + s + 1, "one go per push");
      end
   endtask
   task results;
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      rst_n_i = 1'b0;
      {avs_read_i, avs_write_i, midi_byte_i, key_gain_i, channel_mixer_key_i, enc_push_i} = '0;
      {coax_en, pro_en, opt_en, opt_stereo_det_i, opt_double_id_i, ref_frame_i} = '0;
      {avs_address_i, avs_writedata_i, cyc} = '0;
      {src_in_ratio_i, src_out_ratio_i} = 6'o11;
      for (int i = 0; i < 8; i++) opt_out_ch_i[i*SW +: SW] = SW'(i + 1) * 24'h010101;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      pro_en <= 1'b1;
      t_status;
      t_src;
      t_optin;
      t_panel;
      results;
   end
   initial begin
      #200000;
      fails++;
      results;
   end
endmodule // testbench
bind dio_format_logic dio_format_checker #(.HOLD_CYC(HOLD_CYC)) port_checks (.*);
